// ---- hdl/rx_channel_interrupt_mask.sv ----
// Receive channel interrupt enable, status and APB register slave
//
// Behaviour
// - Masked status 15:8 holds threshold flags, read-only, zero at reset
// - Masked status 7:0 holds packet flags; bits 31:16 reserved
// - Set-register bit 16+n enables channel n pulse interrupt
// - Set-register bit 8+n enables channel n threshold interrupt
// - Set-register bit n enables channel n packet interrupt
// - Set register is write-one-to-set, reads mask, resets zero
// - Clear register has same fields, write-one-to-clear, reads mask
// - A one written to the clear register disables that source
// - Raw status register shows the same flags before masking
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
module rx_channel_interrupt_mask
    import rx_irq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] rx_chan_packet_flag,
    input wire logic [7:0] rx_chan_threshold_flag,
    input wire logic [7:0] rx_chan_pulse_event,
    output logic rx_pulse_irq,
    output logic irq
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [23:0] enable_r, enable_nxt;
    logic [15:0] raw_r, raw_nxt;
    logic [15:0] evt_r, evt_nxt;
    logic [15:0] evt_mask_r, evt_mask_nxt;
    logic [31:0] prdata_nxt;
    logic pslverr_nxt;
    logic pulse_irq_nxt;
    logic irq_nxt;
    logic [15:0] masked;
    logic [15:0] rise;
    logic wr, rd, acc;

    assign acc = psel && penable && pready;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    // Status inputs come from logic on pclk, so no synchroniser is needed
    assign masked = raw_r & enable_r[15:0];
    assign rise = raw_nxt & ~raw_r;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        enable_nxt = enable_r;
        evt_mask_nxt = evt_mask_r;
        raw_nxt = {rx_chan_threshold_flag, rx_chan_packet_flag};
        if (wr && paddr == OFS_ENABLE_SET) begin
            // Zero bits leave the enable alone
            enable_nxt = enable_r
                | pwdata[ENABLE_W-1:0];
        end else if (wr && paddr == OFS_ENABLE_CLEAR) begin
            enable_nxt = enable_r & ~pwdata[ENABLE_W-1:0];
        end else if (wr && paddr == OFS_EVENT_MASK) begin
            evt_mask_nxt = pwdata[STATUS_W-1:0];
        end
        // Sticky event bits: a new rise wins over the read that clears
        evt_nxt = evt_r;
        if (rd && paddr == OFS_EVENT_STATUS) begin
            evt_nxt = STATUS_RESET;
        end
        evt_nxt = evt_nxt | (rise & enable_r[15:0]);
        pulse_irq_nxt =
            |(rx_chan_pulse_event & enable_nxt[PULSE_LSB+:NUM_CHAN]);
        irq_nxt = |(evt_nxt & evt_mask_nxt);
    end

    // ----------------------------------------------------------------
    // APB read mux and answer
    // ----------------------------------------------------------------
    always_comb begin
        prdata_nxt = READ_ZERO;
        pslverr_nxt = 1'b0;
        if (paddr == OFS_STATUS_UNMASKED) begin
            prdata_nxt = {16'h0000, raw_r};
        end else if (paddr == OFS_STATUS_MASKED) begin
            prdata_nxt = {16'h0000, masked};
        end else if (paddr == OFS_ENABLE_SET) begin
            prdata_nxt = {8'h00, enable_r};
        end else if (paddr == OFS_ENABLE_CLEAR) begin
            prdata_nxt = {8'h00, enable_r};
        end else if (paddr == OFS_EVENT_STATUS) begin
            prdata_nxt = {16'h0000, evt_r};
        end else if (paddr == OFS_EVENT_MASK) begin
            prdata_nxt = {16'h0000, evt_mask_r};
        end else begin
            pslverr_nxt = 1'b1;
        end
        // Writes to read-only words are dropped quietly
        if (pwrite || !(psel && !penable)) begin
            prdata_nxt = prdata;
            pslverr_nxt = (psel && !penable) ? pslverr_nxt : pslverr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_r <= ENABLE_RESET;
            raw_r <= STATUS_RESET;
            evt_r <= STATUS_RESET;
            evt_mask_r <= STATUS_RESET;
            prdata <= READ_ZERO;
            pready <= 1'b0;
            pslverr <= 1'b0;
            rx_pulse_irq <= 1'b0;
            irq <= 1'b0;
        end else begin
            enable_r <= enable_nxt;
            raw_r <= raw_nxt;
            evt_r <= evt_nxt;
            evt_mask_r <= evt_mask_nxt;
            prdata <= prdata_nxt;
            // No wait state: ready rises in the first access cycle
            pready <= psel && !penable;
            pslverr <= pslverr_nxt;
            rx_pulse_irq <= pulse_irq_nxt;
            irq <= irq_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_set_write;
        psel && penable && pready && pwrite && paddr == OFS_ENABLE_SET;
    endsequence
    sequence s_clr_write;
        psel && penable && pready && pwrite && paddr == OFS_ENABLE_CLEAR;
    endsequence

    sequence s_setup;
        psel && !penable;
    endsequence

    a_set_pulse_bits: assert property (@(posedge pclk)
        disable iff (!presetn)
        s_set_write |=> (enable_r[23:16] & $past(pwdata[23:16]))
            == $past(pwdata[23:16]))
        else $error("pulse enable not set");
    a_set_thresh_bits: assert property (@(posedge pclk)
        disable iff (!presetn)
        s_set_write |=> (enable_r[15:8] & $past(pwdata[15:8]))
            == $past(pwdata[15:8]))
        else $error("threshold enable not set");
    a_set_packet_bits: assert property (@(posedge pclk)
        disable iff (!presetn)
        s_set_write |=> (enable_r[7:0] & $past(pwdata[7:0]))
            == $past(pwdata[7:0]))
        else $error("packet enable not set");
    a_set_keeps_others: assert property (@(posedge pclk)
        disable iff (!presetn)
        s_set_write |=> (enable_r & $past(enable_r)) == $past(enable_r))
        else $error("set write cleared a bit");
    a_clr_drops_bits: assert property (@(posedge pclk)
        disable iff (!presetn)
        s_clr_write |=> (enable_r & $past(pwdata[23:0])) == 24'h00_0000)
        else $error("clear write left a bit");
    a_clr_keeps_others: assert property (@(posedge pclk)
        disable iff (!presetn)
        s_clr_write |=> (enable_r | $past(enable_r)) == $past(enable_r))
        else $error("clear write set a bit");
    // Checked against the pins a cycle back, not against raw_r
    a_masked_thresh: assert property (@(posedge pclk)
        disable iff (!presetn)
        ##1 masked[15:8]
            == ($past(rx_chan_threshold_flag) & enable_r[15:8]))
        else $error("threshold masked status wrong");
    a_masked_packet: assert property (@(posedge pclk)
        disable iff (!presetn)
        ##1 masked[7:0] == ($past(rx_chan_packet_flag) & enable_r[7:0]))
        else $error("packet masked status wrong");
    a_masked_read: assert property (@(posedge pclk)
        disable iff (!presetn)
        s_setup and (!pwrite && paddr == OFS_STATUS_MASKED)
        |=> prdata == {16'h0000, $past(raw_r & enable_r[15:0])})
        else $error("masked read data wrong");
    a_raw_follows: assert property (@(posedge pclk)
        disable iff (!presetn)
        ##1 raw_r == $past({rx_chan_threshold_flag, rx_chan_packet_flag}))
        else $error("raw status stale");
    a_other_stable: assert property (@(posedge pclk)
        disable iff (!presetn)
        !(wr && (paddr == OFS_ENABLE_SET || paddr == OFS_ENABLE_CLEAR))
        |=> $stable(enable_r))
        else $error("enable changed without write");
    a_ready_answer: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup |=> pready)
        else $error("ready missing after setup");
    a_ready_single: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held too long");
endmodule

// ---- hdl/rx_irq_pkg.sv ----
// Register map and constants of the receive interrupt mask block
package rx_irq_pkg;
    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] OFS_STATUS_UNMASKED = 12'h0_00;
    localparam logic [11:0] OFS_STATUS_MASKED = 12'h0_04;
    localparam logic [11:0] OFS_ENABLE_SET = 12'h0_08;
    localparam logic [11:0] OFS_ENABLE_CLEAR = 12'h0_0C;
    localparam logic [11:0] OFS_EVENT_STATUS = 12'h0_10;
    localparam logic [11:0] OFS_EVENT_MASK = 12'h0_14;
    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam int NUM_CHAN = 8;
    localparam int PACKET_LSB = 0;
    localparam int THRESHOLD_LSB = 8;
    localparam int PULSE_LSB = 16;
    localparam int ENABLE_W = 24;
    localparam int STATUS_W = 16;
    localparam logic [23:0] ENABLE_RESET = 24'h00_0000;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage

// ---- sim/tb.sv ----
// Self-checking bench for the receive interrupt mask block
`timescale 1ns/1ps
module tb;
    import rx_irq_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, rx_pulse_irq, irq;
    logic [7:0] pkt = 8'h00, thr = 8'h00, pulse = 8'h00;
    int miscompares = 0;
    int n_compared = 0;
    always #5 pclk = ~pclk;
    rx_channel_interrupt_mask u_rx_channel_interrupt_mask (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .rx_chan_packet_flag(pkt), .rx_chan_threshold_flag(thr),
        .rx_chan_pulse_event(pulse), .rx_pulse_irq(rx_pulse_irq), .irq(irq)
    );
    // ----------------------------------------------------------------
    // Bus and check tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Holds the request until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input string name, input logic [11:0] a,
                          input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(name, rd, exp);
    endtask
    task automatic final_report();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge pclk);
        miscompares++;
        final_report();
    end
    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("masked_reset", OFS_STATUS_MASKED, 32'h0000_0000);
        rd_chk("set_reset", OFS_ENABLE_SET, 32'h0000_0000);
        rd_chk("clear_reset", OFS_ENABLE_CLEAR, 32'h0000_0000);
        $display("test reset done");
        apb(1'b1, OFS_ENABLE_SET, 32'hFFA5_3C81);
        rd_chk("set_fields", OFS_ENABLE_SET, 32'h00A5_3C81);
        apb(1'b1, OFS_ENABLE_SET, 32'h0000_0000);
        rd_chk("set_zero", OFS_ENABLE_SET, 32'h00A5_3C81);
        apb(1'b1, OFS_ENABLE_CLEAR, 32'h0024_0001);
        rd_chk("clear_fields", OFS_ENABLE_CLEAR, 32'h0081_3C80);
        apb(1'b1, OFS_ENABLE_CLEAR, 32'h0000_0000);
        rd_chk("set_view", OFS_ENABLE_SET, 32'h0081_3C80);
        $display("test enables done");
        pkt <= 8'hFF;
        thr <= 8'hFF;
        repeat (3) @(posedge pclk);
        rd_chk("raw", OFS_STATUS_UNMASKED, 32'h0000_FFFF);
        rd_chk("masked", OFS_STATUS_MASKED, 32'h0000_3C80);
        $display("test status done");
        // Outputs are read at the edge, before that edge updates them
        pulse <= 8'h02;
        repeat (2) @(posedge pclk);
        check("pulse_off", {31'h0, rx_pulse_irq}, 32'h0000_0000);
        pulse <= 8'h80;
        repeat (2) @(posedge pclk);
        check("pulse_on", {31'h0, rx_pulse_irq}, 32'h0000_0001);
        pulse <= 8'h00;
        $display("test pulse done");
        check("irq_masked", {31'h0, irq}, 32'h0000_0000);
        apb(1'b1, OFS_EVENT_MASK, 32'h0000_0080);
        repeat (2) @(posedge pclk);
        check("irq_on", {31'h0, irq}, 32'h0000_0001);
        rd_chk("event", OFS_EVENT_STATUS, 32'h0000_3C80);
        repeat (2) @(posedge pclk);
        check("irq_off", {31'h0, irq}, 32'h0000_0000);
        apb(1'b0, 12'h020, 32'h0000_0000);
        check("unmapped_err", {31'h0, err}, 32'h0000_0001);
        $display("test interrupt done");
        final_report();
    end
endmodule
